// ---- pbcr_pkg.sv ----
// package: register map and field layout of the power budget capability block
package pbcr_pkg;
   localparam logic [11:0] OFF_CAP_HEADER = 12'h280;
   localparam logic [11:0] OFF_INDEX_SELECT = 12'h284;
   localparam logic [11:0] OFF_SELECTED_WORD = 12'h288;
   localparam logic [11:0] OFF_SYS_ALLOC = 12'h28C;
   localparam logic [11:0] OFF_WORD_ARRAY = 12'h300;
   localparam logic [11:0] OFF_CONTROL = 12'h400;
   localparam logic [11:0] OFF_LOADER = 12'h404;
   localparam int CAPABILITY_IDENTIFIER_LSB = 0;
   localparam int CAPABILITY_IDENTIFIER_W = 16;
   localparam int CAPABILITY_VERSION_LSB = 16;
   localparam int CAPABILITY_VERSION_W = 4;
   localparam int NEXT_CAPABILITY_POINTER_LSB = 20;
   localparam int NEXT_CAPABILITY_POINTER_W = 12;
   localparam int INDEX_W = 8;
   localparam int WORD_COUNT = 8;
   localparam int UNLOCK_BIT = 0;
   localparam int LOADER_BIT = 0;
   localparam logic [31:0] HEADER_RST = 32'h0000_0000;
   localparam logic [7:0] INDEX_RST = 8'h00;
   localparam logic SA_RST = 1'b0;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [15:0] CAPABILITY_IDENTIFIER_POWER_BUDGET = 16'h0004;
   localparam logic [3:0] CAPABILITY_VERSION_ONE = 4'h1;
endpackage : pbcr_pkg

// ---- pbcr_word_array.sv ----
// the eight power budget data words with lock and index read port
`timescale 1ns/10ps
module pbcr_word_array #(
   parameter int WORDS = 8,
   parameter int IDX_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [31:0] wr_data,
   input wire logic unlock,
   input wire logic [IDX_W-1:0] sel_idx,
   input wire logic [2:0] rd_idx,
   output logic [31:0] sel_data,
   output logic [31:0] rd_data
);
   typedef struct packed {
      logic [WORDS-1:0][31:0] word;
   } pbcr_arr_s;
   pbcr_arr_s st_ff;
   pbcr_arr_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      // locked writes vanish with no bus error, as software expects
      if (wr_en && unlock) begin
         nxt_st.word[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.word <= {WORDS{pbcr_pkg::WORD_RST}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      // out of range index reads zero
      if (sel_idx < IDX_W'(WORDS)) begin
         sel_data = st_ff.word[sel_idx[2:0]];
      end else begin
         sel_data = 32'h0000_0000;
      end
      rd_data = st_ff.word[rd_idx];
   end
endmodule : pbcr_word_array

// ---- pbcr_regs.sv ----
// APB register bank of the power budgeting capability
`timescale 1ns/10ps
module pbcr_regs #(
   parameter int WORDS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic budget_word_unlock,
   output logic system_allocated_flag
);
   typedef struct packed {
      logic [31:0] header;
      logic [7:0] index;
      logic sys_alloc;
      logic unlock;
      logic loader;
      logic [31:0] rdata;
      logic err;
      logic pend;
   } pbcr_regs_s;
   pbcr_regs_s st_ff;
   pbcr_regs_s nxt_st;

   logic access;
   logic wr;
   logic rd;
   logic arr_hit;
   logic [31:0] sel_data;
   logic [31:0] arr_rd;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] din,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign arr_hit = paddr[11:5] == pbcr_pkg::OFF_WORD_ARRAY[11:5];
   // reads take one wait state so read data stands in a flop at the last edge
   assign pready = !rd || st_ff.pend;
   assign prdata = st_ff.rdata;
   assign pslverr = access && nxt_st.err;
   assign budget_word_unlock = st_ff.unlock;
   assign system_allocated_flag = st_ff.sys_alloc;

   pbcr_word_array #(
      .WORDS(WORDS),
      .IDX_W(pbcr_pkg::INDEX_W)
   ) u_words (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr && arr_hit && pstrb == 4'hF),
      .wr_idx(paddr[4:2]),
      .wr_data(pwdata),
      .unlock(st_ff.unlock),
      .sel_idx(st_ff.index),
      .rd_idx(paddr[4:2]),
      .sel_data(sel_data),
      .rd_data(arr_rd)
   );

   always_comb begin
      logic [31:0] m;
      m = 32'h0000_0000;
      nxt_st = st_ff;
      nxt_st.err = 1'b0;
      nxt_st.pend = rd && !st_ff.pend;
      if (wr) begin
         m = merge(32'h0000_0000, pwdata, pstrb);
         unique case (paddr)
            pbcr_pkg::OFF_CAP_HEADER: begin
               // normal writes are dropped unless the loader gate is open
               if (st_ff.loader) begin
                  nxt_st.header = merge(st_ff.header, pwdata, pstrb);
               end
            end
            pbcr_pkg::OFF_INDEX_SELECT: begin
               if (pstrb[0]) begin
                  nxt_st.index = pwdata[7:0];
               end
            end
            pbcr_pkg::OFF_SYS_ALLOC: begin
               if (st_ff.loader && pstrb[0]) begin
                  nxt_st.sys_alloc = pwdata[0];
               end
            end
            pbcr_pkg::OFF_CONTROL: begin
               if (pstrb[0]) begin
                  nxt_st.unlock = m[pbcr_pkg::UNLOCK_BIT];
               end
            end
            pbcr_pkg::OFF_LOADER: begin
               // loader gate opens on a write of 1; a write of 0 or a reset closes it again
               if (pstrb[0] && m[pbcr_pkg::LOADER_BIT]) begin
                  nxt_st.loader = 1'b1;
               end else if (pstrb[0]) begin
                  nxt_st.loader = 1'b0;
               end
            end
            pbcr_pkg::OFF_SELECTED_WORD: begin
            end
            default: begin
               nxt_st.err = !arr_hit;
            end
         endcase
      end
      if (rd) begin
         unique case (paddr)
            pbcr_pkg::OFF_CAP_HEADER: nxt_st.rdata = st_ff.header;
            pbcr_pkg::OFF_INDEX_SELECT: nxt_st.rdata = {24'h000000, st_ff.index};
            pbcr_pkg::OFF_SELECTED_WORD: nxt_st.rdata = sel_data;
            pbcr_pkg::OFF_SYS_ALLOC: nxt_st.rdata = {31'h0, st_ff.sys_alloc};
            pbcr_pkg::OFF_CONTROL: nxt_st.rdata = {31'h0, st_ff.unlock};
            pbcr_pkg::OFF_LOADER: nxt_st.rdata = {31'h0, st_ff.loader};
            default: begin
               nxt_st.rdata = arr_hit ? arr_rd : 32'h0000_0000;
               nxt_st.err = !arr_hit;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.header <= pbcr_pkg::HEADER_RST;
         st_ff.index <= pbcr_pkg::INDEX_RST;
         st_ff.sys_alloc <= pbcr_pkg::SA_RST;
         st_ff.unlock <= 1'b0;
         st_ff.loader <= 1'b0;
         st_ff.rdata <= 32'h0000_0000;
         st_ff.err <= 1'b0;
         st_ff.pend <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : pbcr_regs

// ---- pbcr_props.sv ----
// checker: port assertions for the power budget register bank
`timescale 1ns/10ps
module pbcr_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic budget_word_unlock,
   input wire logic system_allocated_flag
);
   logic [7:0] idx_ff;
   logic ld_ff, ul_ff;
   wire wr = psel && penable && pwrite;
   wire rd = psel && penable && !pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(a); rd && paddr == a; endsequence
   // sticky flags: the loader gate may close again after opening
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) {idx_ff, ld_ff, ul_ff} <= 10'h000;
      else begin
         if (wr && paddr == 12'h284) idx_ff <= pwdata[7:0];
         if (wr && paddr == 12'h404) ld_ff <= ld_ff | pwdata[0];
         ul_ff <= ul_ff | budget_word_unlock;
      end
   end
   a_idx_back: assert property (s_rd(12'h284) |=>
      prdata == {24'h000000, idx_ff}) else $error("index readback");
   a_idx_high: assert property (s_rd(12'h288) ##0 idx_ff > 8'h07 |=>
      prdata == 32'h0) else $error("high index");
   a_word_rst: assert property (s_rd(12'h288) ##0 !ul_ff |=>
      prdata == 32'h0) else $error("word reset");
   a_hdr_rst: assert property (s_rd(12'h280) ##0 !ld_ff |=>
      prdata == 32'h0) else $error("header reset");
   a_sa_lock: assert property (!ld_ff |-> !system_allocated_flag)
      else $error("flag unloaded");
   a_sa_hold: assert property (!(wr && paddr == 12'h28C) |=>
      $stable(system_allocated_flag)) else $error("flag moved");
   a_ul_set: assert property (wr && paddr == 12'h400 |=>
      budget_word_unlock == $past(pwdata[0])) else $error("unlock value");
   a_ul_hold: assert property (!(wr && paddr == 12'h400) |=>
      $stable(budget_word_unlock)) else $error("unlock moved");
endmodule : pbcr_chk
bind pbcr_regs pbcr_chk u_chk (.*);

// ---- pbcr_regs_tb.sv ----
// testbench: apb register sequences for the power budget bank
`timescale 1ns/10ps
module pbcr_regs_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, unl, sa, slv_err, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   int num_errors = 0, compares = 0;
   pbcr_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr(slv_err),
      .budget_word_unlock(unl), .system_allocated_flag(sa));
   initial forever #5 pclk = ~pclk;
   task automatic close_out;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      repeat (3000) @(posedge pclk);
      num_errors++;
      close_out();
   end
   task automatic chk(string n, logic [31:0] s, e);
      compares++;
      num_errors += int'(s !== e);
      if (s !== e) $display("BAD %s exp %h saw %h", n, e, s);
   endtask : chk
   // data and error are taken at the edge that sees pready high
   task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
      {psel, penable, pwrite} <= {2'b10, w};
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = slv_err;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : acc
   task automatic rd(logic [11:0] a, logic [31:0] e, string n);
      acc(1'b0, a, 32'h0);
      chk(n, r, e);
   endtask : rd
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 16; i += 4)
         rd(12'h280 + 12'(i), 32'h0, "rst");
      rd(12'h200, 32'h0, "unmapped");
      chk("slverr", {31'h0, err}, 32'h1);
      $display("reset test done");
      acc(1'b1, 12'h404, 32'h1);
      acc(1'b1, 12'h280, 32'h5A310004);
      rd(12'h280, 32'h5A310004, "hdr");
      acc(1'b1, 12'h28C, 32'h1);
      chk("sa", {31'h0, sa}, 32'h1);
      acc(1'b1, 12'h404, 32'h0);
      acc(1'b1, 12'h280, 32'h0);
      rd(12'h280, 32'h5A310004, "kept");
      $display("header test done");
      acc(1'b1, 12'h400, 32'h1);
      chk("unlock", {31'h0, unl}, 32'h1);
      for (int i = 0; i < 8; i++)
         acc(1'b1, 12'h300 + 12'(4 * i), 32'hA500 + i);
      acc(1'b1, 12'h400, 32'h0);
      acc(1'b1, 12'h300, 32'hDEAD);
      for (int i = 0; i < 10; i++) begin
         acc(1'b1, 12'h284, (i == 9) ? 32'hFF : 32'(i));
         rd(12'h288, (i < 8) ? 32'hA500 + i : 32'h0, "word");
      end
      $display("word test done");
      close_out();
   end
endmodule : pbcr_regs_tb
